//--- core/lvds_input_pattern_checker.sv
// apb register file, failure record and alarm for the input pattern checker
// How it works
// [RQ1] eight-bit sticky record, one bit per input lane that failed
// [RQ2] record resets to zero; any host write to it clears it, except lanes that fail in the same cycle
// [RQ3] eight host read/write reference words used in turn for checking
// [RQ4] word 0 at index 0x09, resets to 0x7A
// [RQ5] word 1 at index 0x0A, resets to 0xB6
// [RQ6] word 2 at index 0x0B, resets to 0xEA
// [RQ7] word 3 at index 0x0C, resets to 0x45
// [RQ8] word 4 at index 0x0D, resets to 0x1A
// [RQ9] mismatch alarm flag raised when received data differs from reference
// [RQ10] words 5 to 7 follow word 4, reset 0x16, 0xAA, 0xC6
// [RQ11] bytes compared cyclically to words 0..7; differing lanes set sticky
// [RQ12] source sends the eight words repeatedly from word 0 during checking
`timescale 1ns/1ps
module lvds_input_pattern_checker #(
  parameter int unsigned WORDS = pchk_pkg::WORDS,
  parameter int unsigned LANES = pchk_pkg::LANES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pchk_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pchk_pkg::rx_beat_t rx,
  output logic alarm_mismatch,
  output logic irq
);

  // ==========================================================================
  // state
  pchk_pkg::word_bank_t words;
  pchk_pkg::word_bank_t next_words;
  logic [LANES-1:0] record;
  logic [LANES-1:0] next_record;
  logic [pchk_pkg::CTRL_W-1:0] ctrl;
  logic [pchk_pkg::CTRL_W-1:0] next_ctrl;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  pchk_pkg::check_result_t result;
  logic [pchk_pkg::PTR_W-1:0] ptr;
  logic [pchk_pkg::EV_W-1:0] status;
  logic [pchk_pkg::EV_W-1:0] mask;
  logic [pchk_pkg::EV_W-1:0] events;

  // ==========================================================================
  // address decode
  logic [pchk_pkg::IDX_W-1:0] idx;
  logic aligned;
  logic setup;
  logic wr_ok;
  logic hit;
  logic [31:0] rd_value;
  logic [WORDS-1:0] word_we;

  assign idx = paddr[pchk_pkg::ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel & ~penable;
  assign wr_ok = psel & penable & pready & pwrite & ~pslverr;

  always_comb begin
    hit = aligned;
    rd_value = 32'h0;
    if (!aligned) begin
      hit = 1'b0;
    end else if (idx == pchk_pkg::IDX_RECORD) begin
      rd_value = {24'h0, record};
    end else if (idx >= pchk_pkg::IDX_WORD0 && idx <= pchk_pkg::IDX_WORD7) begin
      rd_value = {24'h0, words[pchk_pkg::PTR_W'(idx - pchk_pkg::IDX_WORD0)]};
    end else if (idx == pchk_pkg::IDX_STATUS) begin
      rd_value = {30'h0, status};
    end else if (idx == pchk_pkg::IDX_MASK) begin
      rd_value = {30'h0, mask};
    end else if (idx == pchk_pkg::IDX_CTRL) begin
      rd_value = {30'h0, ctrl};
    end else begin
      hit = 1'b0;
    end
  end

  genvar w;
  generate
    for (w = 0; w < WORDS; w++) begin : g_word_we
      assign word_we[w] = wr_ok &&
        (idx == pchk_pkg::IDX_W'(pchk_pkg::IDX_WORD0 + w)); // RQ3
    end
  endgenerate

  // ==========================================================================
  // apb answer: one wait-free access cycle after setup
  always_comb begin
    next_prdata = 32'h0;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (setup) begin
      next_pready = 1'b1;
      if (!hit) begin
        next_pslverr = 1'b1;
      end else if (!pwrite) begin
        next_prdata = rd_value;
      end
    end
  end

  // ==========================================================================
  // register file
  always_comb begin
    next_words = words;
    next_ctrl = ctrl;
    next_ctrl[pchk_pkg::CTRL_RESTART] = 1'b0;
    next_record = record;
    for (int i = 0; i < WORDS; i++) begin
      if (word_we[i]) begin
        next_words[i] = pwdata[LANES-1:0]; // RQ3
      end
    end
    if (wr_ok && idx == pchk_pkg::IDX_CTRL) begin
      next_ctrl = pwdata[pchk_pkg::CTRL_W-1:0];
    end
    if (wr_ok && idx == pchk_pkg::IDX_RECORD) begin
      next_record = pchk_pkg::RECORD_RESET; // RQ2
    end
    if (result.valid) begin
      next_record = next_record | result.diff; // RQ1
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words <= pchk_pkg::WORD_RESET; // RQ4 RQ5 RQ6 RQ7 RQ8 RQ10
      record <= pchk_pkg::RECORD_RESET; // RQ2
      ctrl <= pchk_pkg::CTRL_RESET;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      words <= next_words;
      record <= next_record;
      ctrl <= next_ctrl;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // checker and events
  word_compare #(
    .WORDS(WORDS),
    .LANES(LANES)
  ) i_word_compare (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl[pchk_pkg::CTRL_ENABLE]),
    .restart(ctrl[pchk_pkg::CTRL_RESTART]),
    .rx(rx),
    .words(words),
    .result(result),
    .ptr(ptr)
  );

  assign events[pchk_pkg::EV_MISMATCH] = result.mismatch; // RQ9
  assign events[pchk_pkg::EV_PASS] = result.pass;

  event_irq #(
    .EV_W(pchk_pkg::EV_W)
  ) i_event_irq (
    .pclk(pclk),
    .presetn(presetn),
    .events(events),
    .clr_we(wr_ok && idx == pchk_pkg::IDX_STATUS),
    .mask_we(wr_ok && idx == pchk_pkg::IDX_MASK),
    .wdata(pwdata[pchk_pkg::EV_W-1:0]),
    .status(status),
    .mask(mask),
    .irq(irq)
  );

  // the alarm flag is the sticky mismatch status bit
  assign alarm_mismatch = status[pchk_pkg::EV_MISMATCH]; // RQ9

  // ==========================================================================
  // assertions
  logic seen_clk;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_clk <= 1'b0;
    end else begin
      seen_clk <= 1'b1;
    end
  end

  record_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ1
    !(wr_ok && idx == pchk_pkg::IDX_RECORD) |=> ((record & $past(record)) == $past(record)))
    else $error("record bit fell without a host write");

  record_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ2
    (wr_ok && idx == pchk_pkg::IDX_RECORD && !result.valid) |=> (record == 8'h00))
    else $error("record not cleared by host write");

  word_write_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    (wr_ok && idx == pchk_pkg::IDX_WORD2) |=> (words[2] == $past(pwdata[7:0])))
    else $error("reference word did not take written value");

  word_zero_rst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ4
    !seen_clk |-> (words[0] == 8'h7A))
    else $error("word 0 reset value wrong");

  word_one_rst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ5
    !seen_clk |-> (words[1] == 8'hB6))
    else $error("word 1 reset value wrong");

  word_two_rst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ6
    !seen_clk |-> (words[2] == 8'hEA))
    else $error("word 2 reset value wrong");

  word_three_rst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ7
    !seen_clk |-> (words[3] == 8'h45))
    else $error("word 3 reset value wrong");

  word_four_rst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ8
    !seen_clk |-> (words[4] == 8'h1A))
    else $error("word 4 reset value wrong");

  upper_words_rst_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ10
    !seen_clk |-> (words[5] == 8'h16 && words[6] == 8'hAA && words[7] == 8'hC6))
    else $error("words 5 to 7 reset values wrong");

  mismatch_alarm_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (ctrl[0] && !ctrl[1] && rx.valid && rx.data != words[ptr]) |=> ##1 alarm_mismatch)
    else $error("alarm not raised two edges after a bad byte");

  lane_capture_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (ctrl[0] && !ctrl[1] && rx.valid) |=> ##1 ((record & $past(rx.data ^ words[ptr], 2))
      == $past(rx.data ^ words[ptr], 2)))
    else $error("differing lanes not recorded");

  pointer_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (ctrl[0] && !ctrl[1] && rx.valid && ptr == 3'h7) |=> (ptr == 3'h0))
    else $error("pointer did not wrap to word 0");

  // ==========================================================================
  // bus, control and pointer checks
  apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
    setup |=> pready)
    else $error("no access cycle after setup");

  apb_single_a: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held for more than one cycle");

  apb_error_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !hit) |=> pslverr)
    else $error("unmapped access not refused");

  error_data_a: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> (pready && prdata == 32'h0))
    else $error("refused access returned data");

  restart_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl[pchk_pkg::CTRL_RESTART] && !(wr_ok && idx == pchk_pkg::IDX_CTRL))
      |=> !ctrl[pchk_pkg::CTRL_RESTART])
    else $error("restart bit did not clear itself");

  word_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ3
    !wr_ok |=> (words == $past(words)))
    else $error("reference word changed without a write");

  pointer_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (!ctrl[pchk_pkg::CTRL_ENABLE] || ctrl[pchk_pkg::CTRL_RESTART]) |=> (ptr == 3'h0))
    else $error("pointer not held at word 0");

  pointer_step_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (ctrl[pchk_pkg::CTRL_ENABLE] && !ctrl[pchk_pkg::CTRL_RESTART] && rx.valid && ptr != 3'h7)
      |=> (ptr == $past(ptr) + 3'h1))
    else $error("pointer did not step on a valid byte");

  checker_off_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ11
    (!ctrl[pchk_pkg::CTRL_ENABLE] || ctrl[pchk_pkg::CTRL_RESTART]) |=> !result.valid)
    else $error("byte compared while checker off");

  alarm_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // RQ9
    (wr_ok && idx == pchk_pkg::IDX_STATUS && pwdata[pchk_pkg::EV_MISMATCH] && !result.mismatch)
      |=> !alarm_mismatch)
    else $error("alarm not cleared by host");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status & mask))
    else $error("interrupt does not follow status and mask");

  cover_mismatch_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(alarm_mismatch));
  cover_pass_c: cover property (@(posedge pclk) disable iff (!presetn)
    result.pass);
  cover_clear_c: cover property (@(posedge pclk) disable iff (!presetn)
    (record != 8'h00) ##1 (wr_ok && idx == pchk_pkg::IDX_RECORD));
  cover_irq_c: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(irq));

endmodule

//--- common/pchk_pkg.sv
// shared constants and carrier types for the lvds input pattern checker
package pchk_pkg;

  // ==========================================================================
  // sizes
  localparam int unsigned LANES = 8;
  localparam int unsigned WORDS = 8;
  localparam int unsigned PTR_W = 3;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned IDX_W = 6;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_RECORD = 6'h08;
  localparam logic [IDX_W-1:0] IDX_WORD0 = 6'h09;
  localparam logic [IDX_W-1:0] IDX_WORD1 = 6'h0A;
  localparam logic [IDX_W-1:0] IDX_WORD2 = 6'h0B;
  localparam logic [IDX_W-1:0] IDX_WORD3 = 6'h0C;
  localparam logic [IDX_W-1:0] IDX_WORD4 = 6'h0D;
  localparam logic [IDX_W-1:0] IDX_WORD5 = 6'h0E;
  localparam logic [IDX_W-1:0] IDX_WORD6 = 6'h0F;
  localparam logic [IDX_W-1:0] IDX_WORD7 = 6'h10;
  localparam logic [IDX_W-1:0] IDX_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_MASK = 6'h21;
  localparam logic [IDX_W-1:0] IDX_CTRL = 6'h22;

  // ==========================================================================
  // reset values and fields
  localparam logic [LANES-1:0] RECORD_RESET = 8'h00;
  localparam logic [WORDS-1:0][LANES-1:0] WORD_RESET = {
    8'hC6, 8'hAA, 8'h16, 8'h1A, 8'h45, 8'hEA, 8'hB6, 8'h7A
  };
  localparam int unsigned CTRL_W = 2;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 2'h0;
  localparam int unsigned CTRL_ENABLE = 0;
  localparam int unsigned CTRL_RESTART = 1;
  localparam int unsigned EV_W = 2;
  localparam int unsigned EV_MISMATCH = 0;
  localparam int unsigned EV_PASS = 1;
  localparam logic [EV_W-1:0] EV_RESET = 2'h0;

  // ==========================================================================
  // carriers
  typedef logic [WORDS-1:0][LANES-1:0] word_bank_t;

  typedef struct packed {
    logic valid;
    logic [LANES-1:0] data;
  } rx_beat_t;

  typedef struct packed {
    logic valid;
    logic mismatch;
    logic pass;
    logic [LANES-1:0] diff;
  } check_result_t;

endpackage

//--- core/word_compare.sv
// cyclic comparison of received bytes against the reference word bank
`timescale 1ns/1ps
module word_compare #(
  parameter int unsigned WORDS = pchk_pkg::WORDS,
  parameter int unsigned LANES = pchk_pkg::LANES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic restart,
  input wire pchk_pkg::rx_beat_t rx,
  input wire pchk_pkg::word_bank_t words,
  output pchk_pkg::check_result_t result,
  output logic [pchk_pkg::PTR_W-1:0] ptr
);

  // ==========================================================================
  // per lane difference
  logic [LANES-1:0] cur_word;
  logic [LANES-1:0] diff;
  assign cur_word = words[ptr];

  genvar lane;
  generate
    for (lane = 0; lane < LANES; lane++) begin : g_lane
      assign diff[lane] = rx.data[lane] ^ cur_word[lane]; // RQ11
    end
  endgenerate

  // ==========================================================================
  // pointer and round tracking
  logic round_err;
  logic next_round_err;
  logic [pchk_pkg::PTR_W-1:0] next_ptr;
  pchk_pkg::check_result_t next_result;

  always_comb begin
    next_ptr = ptr;
    next_round_err = round_err;
    next_result = '0;
    if (!enable || restart) begin
      next_ptr = '0;
      next_round_err = 1'b0;
    end else if (rx.valid) begin
      next_result.valid = 1'b1;
      next_result.diff = diff; // RQ11
      next_result.mismatch = |diff; // RQ9
      if (ptr == pchk_pkg::PTR_W'(WORDS - 1)) begin
        next_result.pass = ~(round_err | (|diff));
        next_round_err = 1'b0;
        next_ptr = '0; // RQ11
      end else begin
        next_round_err = round_err | (|diff);
        next_ptr = ptr + 1'b1; // RQ11
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr <= '0;
      round_err <= 1'b0;
      result <= '0;
    end else begin
      ptr <= next_ptr;
      round_err <= next_round_err;
      result <= next_result;
    end
  end

endmodule

//--- core/event_irq.sv
// sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps
module event_irq #(
  parameter int unsigned EV_W = pchk_pkg::EV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [EV_W-1:0] events,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [EV_W-1:0] wdata,
  output logic [EV_W-1:0] status,
  output logic [EV_W-1:0] mask,
  output logic irq
);

  logic [EV_W-1:0] next_status;
  logic [EV_W-1:0] next_mask;

  // ==========================================================================
  // a new event wins over a clear in the same cycle
  always_comb begin
    next_status = status;
    next_mask = mask;
    if (clr_we) begin
      next_status = status & ~wdata;
    end
    next_status = next_status | events;
    if (mask_we) begin
      next_mask = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= pchk_pkg::EV_RESET;
      mask <= pchk_pkg::EV_RESET;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      irq <= |(next_status & next_mask);
    end
  end

endmodule

//--- verif/pattern_source.sv
// data source model that sends the reference words on the byte-wide link
`timescale 1ns/1ps
module pattern_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [7:0] rounds,
  input wire logic gap,
  input wire logic [2:0] bad_idx,
  input wire logic [7:0] flip,
  input wire pchk_pkg::word_bank_t words,
  output pchk_pkg::rx_beat_t rx,
  output logic busy
);
  logic [10:0] cnt;
  logic hold;

  // ==========================================================================
  // byte sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx <= '0;
      busy <= 1'b0;
      cnt <= 11'h000;
      hold <= 1'b0;
    end else begin
      rx.valid <= 1'b0;
      // idle bus inverts every lane each cycle, so it shows the last byte's inverse and the last byte by turns
      rx.data <= ~rx.data;
      if (start && !busy) begin
        busy <= 1'b1;
        cnt <= 11'h000;
        hold <= 1'b0;
      end else if (busy) begin
        if (gap && !hold) begin
          hold <= 1'b1;
        end else begin
          hold <= 1'b0;
          rx.valid <= 1'b1;
          // whole rounds from word 0, one lane set optionally corrupted
          rx.data <= words[cnt[2:0]] ^ ((cnt[2:0] == bad_idx) ? flip : 8'h00);
          cnt <= cnt + 11'h001;
          if (cnt + 11'h001 == {rounds, 3'h0}) begin
            busy <= 1'b0;
          end
        end
      end
    end
  end
endmodule

//--- verif/test_lvds_input_pattern_checker.sv
// self-checking bench for the lvds input pattern checker
`timescale 1ns/1ps
module test_lvds_input_pattern_checker;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, alarm_mismatch, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic err, start, gap, busy;
  logic [7:0] rounds, flip;
  logic [2:0] bad_idx;
  pchk_pkg::rx_beat_t rx;
  pchk_pkg::word_bank_t ref_w;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;

  lvds_input_pattern_checker i_lvds_input_pattern_checker (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
    .alarm_mismatch(alarm_mismatch), .irq(irq));

  pattern_source i_pattern_source (.pclk(pclk), .presetn(presetn), .start(start),
    .rounds(rounds), .gap(gap), .bad_idx(bad_idx), .flip(flip), .words(ref_w),
    .rx(rx), .busy(busy));

  // ==========================================================================
  // clock, timeout and reporting
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================================
  // apb master, one idle cycle after each transfer
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk(32'(n), 32'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask

  // sends whole rounds and waits until the result has landed
  task automatic run(input logic [7:0] r, input logic [7:0] f, input logic [2:0] idx,
                     input logic g);
    int n;
    n = 0;
    rounds <= r;
    flip <= f;
    bad_idx <= idx;
    gap <= g;
    start <= 1'b1;
    @(posedge pclk);
    start <= 1'b0;
    do begin
      @(posedge pclk);
      n++;
    end while (busy !== 1'b0 && n < 200);
    if (n >= 200) chk(32'h0, 32'h1);
    repeat (3) @(posedge pclk);
  endtask

  // ==========================================================================
  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start = 1'b0;
    gap = 1'b0;
    rounds = 8'h00;
    flip = 8'h00;
    bad_idx = 3'h0;
    ref_w = pchk_pkg::WORD_RESET;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({30'h0, alarm_mismatch, irq}, 32'h0);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 8; i++) begin
      rd_chk(8'h24 + 8'(4 * i), 32'(pchk_pkg::WORD_RESET[i]));
    end
    $display("test reset_values done");
    wr(8'h2C, 32'hFFFF_FF3C);
    ref_w[2] <= 8'h3C;
    rd_chk(8'h2C, 32'h3C);
    apb(1'b0, 8'h44, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    $display("test word_access done");
    wr(8'h84, 32'h1);
    wr(8'h88, 32'h3);
    rd_chk(8'h88, 32'h1);
    run(8'h02, 8'h00, 3'h0, 1'b1);
    rd_chk(8'h20, 32'h0);
    rd_chk(8'h80, 32'h2);
    chk({30'h0, alarm_mismatch, irq}, 32'h0);
    $display("test clean_rounds done");
    run(8'h01, 8'h81, 3'h5, 1'b0);
    rd_chk(8'h20, 32'h81);
    chk({30'h0, alarm_mismatch, irq}, 32'h3);
    wr(8'h20, 32'h0);
    rd_chk(8'h20, 32'h0);
    wr(8'h80, 32'h3);
    chk({30'h0, alarm_mismatch, irq}, 32'h0);
    $display("test lane_fault done");
    wr(8'h84, 32'h0);
    wr(8'h24, 32'h0);
    ref_w[0] <= 8'h00;
    run(8'h01, 8'h10, 3'h7, 1'b1);
    rd_chk(8'h20, 32'h10);
    chk({30'h0, alarm_mismatch, irq}, 32'h2);
    $display("test masked_fault done");
    wr(8'h88, 32'h0);
    wr(8'h20, 32'hFF);
    run(8'h01, 8'hFF, 3'h0, 1'b0);
    rd_chk(8'h20, 32'h0);
    $display("test checker_off done");
    print_verdict();
  end
endmodule
